// File: src/ttp_pkg.sv
// Constants for the triple timer and waveform unit
// What this block does
// - Three independent timers, each with a 16-bit count.
// - Pin timers count input pin events or drive one-shot or duty waveforms.
// - Internal timer has no pins; prescales pin timers or requests DMA.
// - Each timer is serviced once every fourth clock cycle.
// - An input pin event reaches its timer within six clock cycles.
// - An output pin changes within six cycles of its clock event.
// - Each timer has a maximum count that ends its cycle.
// - Pin timers alternate between primary and secondary maximum counts.
// - Core clock is four times the crystal rate, 40 from 10 MHz.
// - Power save slows timers; any interrupt restores full rate.
package ttp_pkg;
    localparam int          TIMER_W      = 16;
    localparam int          NUM_TIMERS   = 3;
    localparam int          NUM_PIN      = 2;
    localparam int          SLOTS        = 4;
    localparam logic [1:0]  SLOT_IDLE    = 2'h3;
    localparam int          XTAL_KHZ     = 10000;
    localparam int          CLK_MULT     = 4;
    localparam int          CORE_KHZ     = XTAL_KHZ * CLK_MULT;
    localparam int          PS_DIV       = 4;
    localparam int          REACT_MAX    = 6;
    localparam logic [15:0] CNT_RST      = 16'h0000;
    localparam logic        TOUT_RST     = 1'b1;
    localparam logic        TIN_IDLE     = 1'b1;
endpackage : ttp_pkg

// File: src/ttp_timer_unit.sv
// Three timer unit with two pin timers and one internal prescale timer
`timescale 1ns/1ns
module ttp_timer_unit #(
    parameter int W      = ttp_pkg::TIMER_W,
    parameter int PS_DIV = ttp_pkg::PS_DIV
) (
    // Clock and reset
    input  wire logic                 clk_sys_in,
    input  wire logic                 arst_n_in,
    // Timer pins
    input  wire logic [1:0]           tin_in,
    output logic      [1:0]           tout_out,
    // Per timer setup, index 2 is the internal prescale timer
    input  wire logic [2:0]           en_in,
    input  wire logic [2:0]           cont_in,
    input  wire logic [1:0]           ext_clk_in,
    input  wire logic [1:0]           prescale_in,
    input  wire logic [1:0]           alt_in,
    input  wire logic [2:0][W-1:0]    max_a_in,
    input  wire logic [1:0][W-1:0]    max_b_in,
    // Power save and interrupt
    input  wire logic                 ps_req_in,
    input  wire logic                 irq_in,
    // Status
    output logic      [2:0][W-1:0]    cnt_out,
    output logic      [2:0]           done_out,
    output logic      [1:0]           limit_sel_out,
    output logic                      dreq_out,
    output logic                      ps_active_out
);
    if (W != ttp_pkg::TIMER_W || PS_DIV < 1 || PS_DIV > 256) begin : g_bad_cfg
        $error("ttp_timer_unit: unsupported W or PS_DIV");
    end
    if (ttp_pkg::CORE_KHZ != ttp_pkg::XTAL_KHZ * 4) begin : g_bad_clk
        $error("ttp_timer_unit: core clock must be four times the crystal");
    end

    function automatic logic at_limit(input logic [W-1:0] c, input logic [W-1:0] l);
        at_limit = (c == l);
    endfunction : at_limit

    logic [1:0]          slot_r;
    logic [7:0]          ps_cnt_r;
    logic                ps_r;
    logic [2:0]          en_q_r;
    logic [2:0]          run_r;
    logic [1:0]          tin_q_r;
    logic [1:0]          pend_ext_r;
    logic [1:0]          pend_pre_r;
    logic [1:0]          sel_r;
    logic [1:0]          tout_r;
    logic [2:0][W-1:0]   cnt_r;
    logic [2:0]          done_r;
    logic                dreq_r;
    logic                round_ok;
    logic [2:0]          svc;
    logic [2:0]          tick;
    logic [2:0]          wrap;
    logic [2:0][W-1:0]   lim;
    logic [2:0]          alt_hold;

    // Slot, tick source and limit selection
    always_comb begin
        round_ok = !ps_r || (ps_cnt_r == 8'h00);
        for (int i = 0; i < 3; i++) begin
            svc[i] = (slot_r == 2'(i)) && round_ok;
        end
        tick[2]     = 1'b1;
        lim[2]      = max_a_in[2];
        alt_hold[2] = 1'b0;
        for (int i = 0; i < 2; i++) begin
            tick[i] = ext_clk_in[i] ? pend_ext_r[i] :
                      prescale_in[i] ? pend_pre_r[i] : 1'b1;
            lim[i]  = (alt_in[i] && sel_r[i]) ? max_b_in[i] : max_a_in[i];
            // Single shot in alternate mode runs on through the primary cycle
            alt_hold[i] = alt_in[i] && !sel_r[i];
        end
        for (int i = 0; i < 3; i++) begin
            wrap[i] = svc[i] && run_r[i] && tick[i] && at_limit(cnt_r[i], lim[i]);
        end
    end

    // Service slot rotation
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            slot_r <= 2'h0;
        end else begin
            slot_r <= slot_r + 2'h1;
        end
    end

    // Power save state and round divider
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ps_r     <= 1'b0;
            ps_cnt_r <= 8'h00;
        end else begin
            if (irq_in) begin
                ps_r <= 1'b0;
            end else if (ps_req_in) begin
                ps_r <= 1'b1;
            end
            if (!ps_r) begin
                ps_cnt_r <= 8'h00;
            end else if (slot_r == ttp_pkg::SLOT_IDLE) begin
                ps_cnt_r <= (ps_cnt_r == 8'(PS_DIV - 1)) ? 8'h00 : ps_cnt_r + 8'h01;
            end
        end
    end

    // Run control, one shot stops after its cycle
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            en_q_r <= 3'h0;
            run_r  <= 3'h0;
        end else begin
            en_q_r <= en_in;
            for (int i = 0; i < 3; i++) begin
                if (!en_in[i]) begin
                    run_r[i] <= 1'b0;
                end else if (!en_q_r[i]) begin
                    run_r[i] <= 1'b1;
                end else if (wrap[i] && !cont_in[i] && !alt_hold[i]) begin
                    run_r[i] <= 1'b0;
                end
            end
        end
    end

    // Pending input events and prescale ticks; a new event beats the clear
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            tin_q_r    <= {2{ttp_pkg::TIN_IDLE}};
            pend_ext_r <= 2'h0;
            pend_pre_r <= 2'h0;
        end else begin
            tin_q_r <= tin_in;
            for (int i = 0; i < 2; i++) begin
                if (tin_in[i] && !tin_q_r[i]) begin
                    pend_ext_r[i] <= 1'b1;
                end else if (svc[i]) begin
                    pend_ext_r[i] <= 1'b0;
                end
                if (wrap[2]) begin
                    pend_pre_r[i] <= 1'b1;
                end else if (svc[i]) begin
                    pend_pre_r[i] <= 1'b0;
                end
            end
        end
    end

    // Counters
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt_r <= {3{ttp_pkg::CNT_RST}};
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (en_in[i] && !en_q_r[i]) begin
                    cnt_r[i] <= ttp_pkg::CNT_RST;
                end else if (wrap[i]) begin
                    cnt_r[i] <= ttp_pkg::CNT_RST;
                end else if (svc[i] && run_r[i] && tick[i]) begin
                    cnt_r[i] <= cnt_r[i] + 16'h0001;
                end
            end
        end
    end

    // Limit select and pin outputs
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sel_r  <= 2'h0;
            tout_r <= {2{ttp_pkg::TOUT_RST}};
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (!alt_in[i]) begin
                    sel_r[i] <= 1'b0;
                    if (wrap[i]) begin
                        tout_r[i] <= 1'b0;
                    end else if (svc[i]) begin
                        tout_r[i] <= 1'b1;
                    end
                end else if (wrap[i]) begin
                    sel_r[i]  <= ~sel_r[i];
                    tout_r[i] <= sel_r[i];
                end
            end
        end
    end

    // Completion pulses and DMA request
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            done_r <= 3'h0;
            dreq_r <= 1'b0;
        end else begin
            done_r <= wrap;
            dreq_r <= wrap[2];
        end
    end

    assign tout_out      = tout_r;
    assign cnt_out       = cnt_r;
    assign done_out      = done_r;
    assign limit_sel_out = sel_r;
    assign dreq_out      = dreq_r;
    assign ps_active_out = ps_r;

    svc_spacing_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        svc[0] |=> !svc[0] [*3])
        else $error("timer serviced more often than every fourth cycle");
    ext_react_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        ($rose(pend_ext_r[0]) && !ps_r && !ps_req_in) |-> ##[0:3] (svc[0] && pend_ext_r[0]))
        else $error("input event not taken within six cycles");
    out_resp_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        $changed(tout_r[0]) |-> $past(svc[0]))
        else $error("output changed outside its service slot");
    wrap_zero_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        wrap[1] |=> cnt_r[1] == 16'h0000)
        else $error("count did not restart at maximum");
    alt_swap_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        (wrap[1] && alt_in[1]) |=> (sel_r[1] != $past(sel_r[1])) && (tout_r[1] == !sel_r[1]))
        else $error("alternate limit or level not swapped");
    ps_exit_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        irq_in |=> !ps_r ##1 (svc[0] || svc[1] || svc[2] || slot_r == ttp_pkg::SLOT_IDLE))
        else $error("interrupt did not restore full rate");
    dreq_pulse_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        wrap[2] |=> dreq_r ##1 !dreq_r)
        else $error("dma request not a one cycle pulse on wrap");
    cnt_step_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        $changed(cnt_r[2]) |-> (cnt_r[2] == 16'h0000 || cnt_r[2] == $past(cnt_r[2]) + 16'h0001))
        else $error("count moved by other than one");
    one_shot_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        (wrap[2] && !cont_in[2] && en_q_r[2] && en_in[2]) |=> !run_r[2])
        else $error("single shot timer kept running");
endmodule : ttp_timer_unit

// File: bench/ttp_pin_src.sv
// Event source model driving the two timer input pins
`timescale 1ns/1ns
module ttp_pin_src (
    // Clock and reset
    input  wire logic       clk_sys_in,
    input  wire logic       arst_n_in,
    // One-cycle request for an event per pin
    input  wire logic [1:0] fire_in,
    // Pins, idle high as with a pull-up
    output logic      [1:0] tin_out
);
    for (genvar i = 0; i < 2; i++) begin : g_pin
        logic [1:0] low_r;
        // Low for two cycles, the rising edge on return is the event
        always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
            if (!arst_n_in) begin
                low_r <= 2'h0;
            end else if (fire_in[i] && low_r == 2'h0) begin
                low_r <= 2'h2;
            end else if (low_r != 2'h0) begin
                low_r <= low_r - 2'h1;
            end
        end
        assign tin_out[i] = (low_r == 2'h0);
    end
endmodule : ttp_pin_src

// File: bench/triple_timer_pwm_unit_tb.sv
// Self-checking bench for the triple timer unit
`timescale 1ns/1ns
module triple_timer_pwm_unit_tb;
    logic             clk_sys_in, arst_n_in, ps_req, irq, dreq, ps_act;
    logic [1:0]       tin, tout, ext_clk, pre, alt, fire, sel;
    logic [2:0]       en, cont, done;
    logic [2:0][15:0] max_a, cnt;
    logic [1:0][15:0] max_b;
    int               failures, n_tests, cyc, t, lo, hi;

    ttp_timer_unit #(.PS_DIV(2)) ttp_timer_unit_inst (.clk_sys_in(clk_sys_in),
        .arst_n_in(arst_n_in), .tin_in(tin), .tout_out(tout), .en_in(en), .cont_in(cont),
        .ext_clk_in(ext_clk), .prescale_in(pre), .alt_in(alt), .max_a_in(max_a),
        .max_b_in(max_b), .ps_req_in(ps_req), .irq_in(irq), .cnt_out(cnt), .done_out(done),
        .limit_sel_out(sel), .dreq_out(dreq), .ps_active_out(ps_act));
    ttp_pin_src ttp_pin_src_inst (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
        .fire_in(fire), .tin_out(tin));

    always #5 clk_sys_in = ~clk_sys_in;

    task chk(input bit ok, input string m);
        n_tests++;
        if (!ok) begin
            failures++;
            $display("MISMATCH t=%0t %s", $time, m);
        end
    endtask : chk

    task wait_dreq(output int n);
        n = 0;
        @(negedge clk_sys_in);
        while (dreq !== 1'b1 && n < 200) begin
            @(negedge clk_sys_in);
            n++;
        end
    endtask : wait_dreq

    task run_len(input int b, input logic lvl, output int n);
        n = 0;
        while (tout[b] === lvl && n < 100) begin
            @(negedge clk_sys_in);
            n++;
        end
    endtask : run_len

    task t_internal;
        @(posedge clk_sys_in);
        max_a[2] <= 16'h0003;
        cont[2]  <= 1'b1;
        en[2]    <= 1'b1;
        wait_dreq(t);
        wait_dreq(t);
        chk(t == 15, "internal period");
        chk(done[2] === 1'b1, "done with dreq");
        @(posedge clk_sys_in);
        ps_req <= 1'b1;
        @(posedge clk_sys_in);
        ps_req <= 1'b0;
        wait_dreq(t);
        wait_dreq(t);
        chk(t == 31 && ps_act === 1'b1, "power save period");
        @(posedge clk_sys_in);
        irq <= 1'b1;
        @(posedge clk_sys_in);
        irq <= 1'b0;
        wait_dreq(t);
        wait_dreq(t);
        chk(t == 15 && ps_act === 1'b0, "full rate back");
        @(posedge clk_sys_in);
        cont[2] <= 1'b0;
        wait_dreq(t);
        wait_dreq(t);
        chk(t == 200, "single shot stopped");
    endtask : t_internal

    task t_ext;
        logic [15:0] c0;
        @(posedge clk_sys_in);
        ext_clk[0] <= 1'b1;
        max_a[0]   <= 16'h00ff;
        cont[0]    <= 1'b1;
        en[0]      <= 1'b1;
        repeat (8) @(posedge clk_sys_in);
        for (int k = 0; k < 4; k++) begin
            c0 = cnt[0];
            fire[0] <= 1'b1;
            @(posedge clk_sys_in);
            fire[0] <= 1'b0;
            @(posedge tin[0]);
            t = 0;
            while (cnt[0] === c0 && t < 20) begin
                @(posedge clk_sys_in);
                #1;
                t++;
            end
            chk(t <= 6, "pin reaction");
            repeat (6) @(posedge clk_sys_in);
        end
        chk(cnt[0] === 16'h0004, "pin event count");
    endtask : t_ext

    task t_alt;
        @(posedge clk_sys_in);
        max_a[1] <= 16'h0002;
        max_b[1] <= 16'h0001;
        alt[1]   <= 1'b1;
        cont[1]  <= 1'b1;
        en[1]    <= 1'b1;
        @(negedge clk_sys_in);
        run_len(1, 1'b1, t);
        chk(sel[1] === 1'b1, "secondary selected");
        run_len(1, 1'b0, lo);
        run_len(1, 1'b1, hi);
        chk(lo == 8 && hi == 12, "duty lengths");
    endtask : t_alt

    task t_pre;
        @(posedge clk_sys_in);
        en[0]      <= 1'b0;
        en[2]      <= 1'b0;
        @(posedge clk_sys_in);
        en         <= 3'h7;
        ext_clk[0] <= 1'b0;
        pre[0]     <= 1'b1;
        max_a[0]   <= 16'h0001;
        max_a[2]   <= 16'h0000;
        cont[2]    <= 1'b1;
        @(negedge clk_sys_in);
        run_len(0, 1'b1, t);
        chk(done[0] === 1'b1 && tout[0] === 1'b0, "wrap pulse with low output");
        run_len(0, 1'b0, lo);
        run_len(0, 1'b1, hi);
        chk(lo == 4 && hi == 4, "prescaled output period");
    endtask : t_pre

    task tally_and_finish;
        $display("failures=%0d n_tests=%0d", failures, n_tests);
        if (failures == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish

    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 4000) begin
            failures++;
            tally_and_finish();
        end
    end

    initial begin
        {clk_sys_in, arst_n_in, ps_req, irq} = 4'h0;
        {ext_clk, pre, alt, fire, en, cont} = '0;
        max_a = '0;
        max_b = '0;
        failures = 0;
        n_tests  = 0;
        cyc      = 0;
        repeat (3) @(posedge clk_sys_in);
        #1;
        chk(cnt === '0 && tout === 2'h3 && done === 3'h0, "reset values");
        @(posedge clk_sys_in);
        arst_n_in <= 1'b1;
        t_internal();
        t_ext();
        t_alt();
        t_pre();
        tally_and_finish();
    end
endmodule : triple_timer_pwm_unit_tb
